// [pdcp_peak_decode.sv]
`timescale 1ns/10ps
// ==========================================================
// registered code to percent lookup for one gate-drive side
module pdcp_peak_decode (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] code,
    output logic [pdcp_pkg::PCT_W-1:0] percent_reg
);

    logic [pdcp_pkg::PCT_W-1:0] percent_next;

    // table lookup; one entry per code
    always_comb begin
        percent_next = pdcp_pkg::PEAK_PCT_TABLE[code*pdcp_pkg::PCT_W +: pdcp_pkg::PCT_W];
    end

    // reset value matches code 000
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            percent_reg <= pdcp_pkg::PEAK_PCT_TABLE[pdcp_pkg::PCT_W-1:0];
        end else begin
            percent_reg <= percent_next;
        end
    end

endmodule

// [pdcp_pkg.sv]
// Notes on behaviour
// - high-side peak code 000..111 gives 100,95,90,80,65,55,40,30 percent drive.
// - low-side peak code is its own 3-bit field; 000 is 100 percent, then lower.
// - pump divider register resets to 01h, dividing the pump clock by 24.
// - divider code 00,01,10,11 selects 1/18, 1/24, 1/36, 1/40.
// - boost control resets to 02h: double boost on, 10V off, 6.5V on.
// - boost disable bit at 0 enables double boost, at 1 disables it.
// - 10V pump enable bit at 0 forbids, at 1 permits; resets to 0.
// - 6.5V pump enable bit at 0 forbids, at 1 permits; resets to 1.
package pdcp_pkg;

    // ==========================================================
    // bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ==========================================================
    // register indices and byte addresses (byte address is four times the index)
    localparam logic [7:0] IDX_PEAK = 8'h30;
    localparam logic [7:0] IDX_DIV = 8'h32;
    localparam logic [7:0] IDX_BOOST = 8'h34;
    localparam logic [ADDR_W-1:0] ADDR_PEAK = {IDX_PEAK[5:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_DIV = {IDX_DIV[5:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_BOOST = {IDX_BOOST[5:0], 2'h0};

    // ==========================================================
    // values after reset
    localparam logic [7:0] RST_PEAK = 8'h00;
    localparam logic [7:0] RST_DIV = 8'h01;
    localparam logic [7:0] RST_BOOST = 8'h02;

    // ==========================================================
    // writable bit masks and field positions
    localparam logic [7:0] MASK_PEAK = 8'h77;
    localparam logic [7:0] MASK_DIV = 8'h03;
    localparam logic [7:0] MASK_BOOST = 8'h07;
    localparam int HIGH_LSB = 4;
    localparam int LOW_LSB = 0;
    localparam int DIV_LSB = 0;
    localparam int BOOST_N_BIT = 0;
    localparam int SIX_HALF_BIT = 1;
    localparam int TEN_BIT = 2;

    // ==========================================================
    // divide ratios per divider code
    localparam logic [5:0] DIV_RATIO_0 = 6'h12;
    localparam logic [5:0] DIV_RATIO_1 = 6'h18;
    localparam logic [5:0] DIV_RATIO_2 = 6'h24;
    localparam logic [5:0] DIV_RATIO_3 = 6'h28;

    // ==========================================================
    // peak level in percent, 7 bits per code, code 0 in the low bits
    localparam int PCT_W = 7;
    localparam logic [8*PCT_W-1:0] PEAK_PCT_TABLE = {
        7'h1E, 7'h28, 7'h37, 7'h41, 7'h50, 7'h5A, 7'h5F, 7'h64
    };

    // ==========================================================
    // carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [3:0] pstrb;
    } pdcp_apb_req_t;

    typedef struct packed {
        logic [2:0] high_side_peak_level;
        logic [2:0] low_side_peak_level;
        logic [1:0] pump_divider_select;
        logic double_boost_disable;
        logic ten_volt_pump_enable;
        logic six_half_volt_pump_enable;
    } pdcp_cfg_t;

endpackage

// [pdcp_top.sv]
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
// ==========================================================
// pre-driver and charge pump configuration bank, APB slave
module pdcp_top (
    input wire logic pclk,
    input wire logic presetn,
    input pdcp_pkg::pdcp_apb_req_t apb_req,
    output logic pready,
    output logic [pdcp_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    input wire logic pump_powersave_release,
    input wire logic pump_regulator_powersave_release,
    output pdcp_pkg::pdcp_cfg_t cfg,
    output logic [pdcp_pkg::PCT_W-1:0] high_side_peak_percent,
    output logic [pdcp_pkg::PCT_W-1:0] low_side_peak_percent,
    output logic [5:0] pump_divide_ratio,
    output logic double_boost_enable
);

    // ==========================================================
    // storage
    logic [7:0] peak_reg;
    logic [7:0] peak_next;
    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic [7:0] boost_reg;
    logic [7:0] boost_next;

    // ==========================================================
    // bus answer state
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [pdcp_pkg::DATA_W-1:0] prdata_reg;
    logic [pdcp_pkg::DATA_W-1:0] prdata_next;

    // ==========================================================
    // decoded outputs kept in flops
    logic [5:0] ratio_reg;
    logic [5:0] ratio_next;
    logic boost_en_reg;
    logic boost_en_next;

    // ==========================================================
    // address decode and phase qualifiers
    logic setup_phase;
    logic write_commit;
    logic hit_peak;
    logic hit_div;
    logic hit_boost;
    logic mapped;
    logic locked;
    logic [7:0] read_byte;
    logic [7:0] wr_byte;

    // phase detection
    assign setup_phase = apb_req.psel & ~apb_req.penable;
    assign hit_peak = (apb_req.paddr == pdcp_pkg::ADDR_PEAK);
    assign hit_div = (apb_req.paddr == pdcp_pkg::ADDR_DIV);
    assign hit_boost = (apb_req.paddr == pdcp_pkg::ADDR_BOOST);
    assign mapped = hit_peak | hit_div | hit_boost;
    // a write is committed only at the access edge that also returns ready without error
    assign write_commit = apb_req.psel & apb_req.penable & apb_req.pwrite & pready_reg & ~pslverr_reg;
    assign wr_byte = apb_req.pwdata[7:0];

    // lock check: pump settings stay frozen while the related power-save is released
    always_comb begin
        locked = 1'b0;
        if (hit_div) begin
            locked = pump_powersave_release;
        end else if (hit_boost) begin
            locked = pump_regulator_powersave_release;
        end
    end

    // read mux; unused bits already held at zero in storage
    always_comb begin
        read_byte = 8'h00;
        if (hit_peak) begin
            read_byte = peak_reg;
        end else if (hit_div) begin
            read_byte = div_reg;
        end else if (hit_boost) begin
            read_byte = boost_reg;
        end
    end

    // ==========================================================
    // bus answer: ready, error and read data are prepared in the setup cycle
    // so every access phase completes at its first edge, with no wait state
    always_comb begin
        pready_next = setup_phase;
        pslverr_next = 1'b0;
        prdata_next = '0;
        if (setup_phase) begin
            // unmapped addresses and writes against a released power-save both answer with an error
            pslverr_next = ~mapped | (apb_req.pwrite & locked);
            if (!apb_req.pwrite) begin
                prdata_next = {24'h000000, read_byte};
            end
        end
    end

    // bus answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    // ==========================================================
    // register file next values; only byte lane 0 carries data
    always_comb begin
        peak_next = peak_reg;
        div_next = div_reg;
        boost_next = boost_reg;
        if (write_commit && apb_req.pstrb[0]) begin
            if (hit_peak) begin
                peak_next = wr_byte & pdcp_pkg::MASK_PEAK;
            end
            if (hit_div) begin
                div_next = wr_byte & pdcp_pkg::MASK_DIV;
            end
            if (hit_boost) begin
                boost_next = wr_byte & pdcp_pkg::MASK_BOOST;
            end
        end
    end

    // register file flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peak_reg <= pdcp_pkg::RST_PEAK;
            div_reg <= pdcp_pkg::RST_DIV;
            boost_reg <= pdcp_pkg::RST_BOOST;
        end else begin
            peak_reg <= peak_next;
            div_reg <= div_next;
            boost_reg <= boost_next;
        end
    end

    // ==========================================================
    // decoded pump settings; one cycle behind the register, trading latency for flop outputs
    always_comb begin
        case (div_reg[pdcp_pkg::DIV_LSB +: 2])
            2'h0: ratio_next = pdcp_pkg::DIV_RATIO_0;
            2'h1: ratio_next = pdcp_pkg::DIV_RATIO_1;
            2'h2: ratio_next = pdcp_pkg::DIV_RATIO_2;
            2'h3: ratio_next = pdcp_pkg::DIV_RATIO_3;
            default: ratio_next = pdcp_pkg::DIV_RATIO_1;
        endcase
        // boost disable is active low in sense: zero turns double boost on
        boost_en_next = ~boost_reg[pdcp_pkg::BOOST_N_BIT];
    end

    // decoded flops; reset values agree with the register reset values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ratio_reg <= pdcp_pkg::DIV_RATIO_1;
            boost_en_reg <= 1'b1;
        end else begin
            ratio_reg <= ratio_next;
            boost_en_reg <= boost_en_next;
        end
    end

    // ==========================================================
    // peak level lookups, one per side
    pdcp_peak_decode u_high_decode (
        .pclk(pclk),
        .presetn(presetn),
        .code(peak_reg[pdcp_pkg::HIGH_LSB +: 3]),
        .percent_reg(high_side_peak_percent)
    );

    pdcp_peak_decode u_low_decode (
        .pclk(pclk),
        .presetn(presetn),
        .code(peak_reg[pdcp_pkg::LOW_LSB +: 3]),
        .percent_reg(low_side_peak_percent)
    );

    // ==========================================================
    // outputs, all straight from flops
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;
    assign pump_divide_ratio = ratio_reg;
    assign double_boost_enable = boost_en_reg;
    assign cfg.high_side_peak_level = peak_reg[pdcp_pkg::HIGH_LSB +: 3];
    assign cfg.low_side_peak_level = peak_reg[pdcp_pkg::LOW_LSB +: 3];
    assign cfg.pump_divider_select = div_reg[pdcp_pkg::DIV_LSB +: 2];
    assign cfg.double_boost_disable = boost_reg[pdcp_pkg::BOOST_N_BIT];
    assign cfg.ten_volt_pump_enable = boost_reg[pdcp_pkg::TEN_BIT];
    assign cfg.six_half_volt_pump_enable = boost_reg[pdcp_pkg::SIX_HALF_BIT];

endmodule

// [pdcp_top_assertions.sv]
`timescale 1ns/10ps
// ==========================================================
// port checker for the configuration bank
module pdcp_chk (
    input wire logic pclk,
    input wire logic presetn,
    input pdcp_pkg::pdcp_apb_req_t apb_req,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic pump_powersave_release,
    input wire logic pump_regulator_powersave_release,
    input pdcp_pkg::pdcp_cfg_t cfg,
    input wire logic [6:0] high_side_peak_percent,
    input wire logic [6:0] low_side_peak_percent,
    input wire logic [5:0] pump_divide_ratio,
    input wire logic double_boost_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // divide ratios packed with code 0 in the low bits, so the code indexes the table
    localparam logic [23:0] RATIO_TABLE = {pdcp_pkg::DIV_RATIO_3, pdcp_pkg::DIV_RATIO_2,
        pdcp_pkg::DIV_RATIO_1, pdcp_pkg::DIV_RATIO_0};

    // locked write setups, lock sampled with the setup cycle
    sequence div_lock_s;
        apb_req.psel && !apb_req.penable && apb_req.pwrite && apb_req.paddr == pdcp_pkg::ADDR_DIV
            && pump_powersave_release;
    endsequence
    sequence boost_lock_s;
        apb_req.psel && !apb_req.penable && apb_req.pwrite && apb_req.paddr == pdcp_pkg::ADDR_BOOST
            && pump_regulator_powersave_release;
    endsequence
    sequence rd_access_s;
        pready && apb_req.penable && !apb_req.pwrite;
    endsequence

    // decoded outputs trail the register by one cycle
    high_pct_a: assert property (1 |=> high_side_peak_percent ==
        pdcp_pkg::PEAK_PCT_TABLE[$past(cfg.high_side_peak_level)*7 +: 7])
        else $error("high side percent wrong");
    low_pct_a: assert property (1 |=> low_side_peak_percent ==
        pdcp_pkg::PEAK_PCT_TABLE[$past(cfg.low_side_peak_level)*7 +: 7])
        else $error("low side percent wrong");
    div_ratio_a: assert property (1 |=> pump_divide_ratio ==
        RATIO_TABLE[$past(cfg.pump_divider_select)*6 +: 6])
        else $error("divide ratio wrong");
    boost_enable_a: assert property (1 |=> double_boost_enable == !$past(cfg.double_boost_disable))
        else $error("double boost enable wrong");
    reset_vals_a: assert property ($rose(presetn) |-> cfg == 11'h009)
        else $error("reset values wrong");
    div_lock_a: assert property (div_lock_s |=> pready && pslverr ##1 $stable(cfg.pump_divider_select))
        else $error("locked divider write took effect");
    boost_lock_a: assert property (boost_lock_s |=> pready && pslverr ##1 $stable(cfg[2:0]))
        else $error("locked boost write took effect");
    peak_read_a: assert property ((rd_access_s and (apb_req.paddr == pdcp_pkg::ADDR_PEAK)) |->
        prdata == {25'h0, cfg.high_side_peak_level, 1'b0, cfg.low_side_peak_level}) else $error("peak read wrong");
    div_read_a: assert property ((rd_access_s and (apb_req.paddr == pdcp_pkg::ADDR_DIV)) |->
        prdata == {30'h0, cfg.pump_divider_select}) else $error("divider read wrong");
endmodule

bind pdcp_top pdcp_chk i_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pump_powersave_release(pump_powersave_release),
    .pump_regulator_powersave_release(pump_regulator_powersave_release), .cfg(cfg),
    .high_side_peak_percent(high_side_peak_percent), .low_side_peak_percent(low_side_peak_percent),
    .pump_divide_ratio(pump_divide_ratio), .double_boost_enable(double_boost_enable));

// [predriver_chargepump_config_test.sv]
`timescale 1ns/10ps
// ==========================================================
// self-checking bench with an integer model of the bank
module predriver_chargepump_config_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pps = 1'b0;
    logic prps = 1'b0;
    pdcp_pkg::pdcp_apb_req_t req = '0;
    pdcp_pkg::pdcp_cfg_t cfg;
    logic pready, pslverr, dbe, e;
    logic [31:0] prdata, rd;
    logic [6:0] hi_pct, lo_pct;
    logic [5:0] ratio;
    logic [7:0] adr[4] = '{pdcp_pkg::ADDR_PEAK, pdcp_pkg::ADDR_DIV, pdcp_pkg::ADDR_BOOST, 8'hC4};
    int pct[8] = '{100, 95, 90, 80, 65, 55, 40, 30};
    int div[4] = '{18, 24, 36, 40};
    int err_total = 0;
    int comparisons = 0;
    int m_peak, m_div, m_boost, lk_d, lk_b, i;

    // free-running 40 MHz clock
    always #12.5 pclk = ~pclk;

    pdcp_top i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pump_powersave_release(pps), .pump_regulator_powersave_release(prps), .cfg(cfg),
        .high_side_peak_percent(hi_pct), .low_side_peak_percent(lo_pct), .pump_divide_ratio(ratio),
        .double_boost_enable(dbe));

    // ==========================================================
    // reporting
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // ==========================================================
    // bus cycles; signals change right after a rising edge, pready and data are taken at the edge itself
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        req.pstrb <= s;
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_total++;
            end_of_test();
        end else begin
            rd = prdata;
            e = pslverr;
            req.penable <= 1'b0;
        end
    endtask

    // psel stays up between calls so transfers can run back to back
    task automatic idle();
        req.psel <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic lock(input int d, input int b);
        lk_d = d;
        lk_b = b;
        pps <= d[0];
        prps <= b[0];
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int x;
        x = (a == adr[0]) ? 0 : (a == adr[1]) ? lk_d : (a == adr[2]) ? lk_b : 1;
        if (x == 0 && s[0] && a == adr[0]) m_peak = d[7:0] & 8'h77;
        if (x == 0 && s[0] && a == adr[1]) m_div = d[1:0];
        if (x == 0 && s[0] && a == adr[2]) m_boost = d[2:0];
        xfer(1'b1, a, d, s);
        check({31'h0, e}, x);
    endtask

    task automatic rdchk(input logic [7:0] a);
        int x;
        x = (a == adr[0]) ? m_peak : (a == adr[1]) ? m_div : (a == adr[2]) ? m_boost : 0;
        xfer(1'b0, a, $urandom, 4'h0);
        check(rd, x);
        check({31'h0, e}, (a == adr[3] || a == 8'h30) ? 1 : 0);
    endtask

    // outputs are compared two cycles after the last write
    task automatic outs();
        @(posedge pclk);
        check(32'(cfg), {m_peak[6:4], m_peak[2:0], m_div[1:0], m_boost[0], m_boost[2], m_boost[1]});
        check(32'(hi_pct), pct[m_peak[6:4]]);
        check(32'(lo_pct), pct[m_peak[2:0]]);
        check(32'(ratio), div[m_div]);
        check({31'h0, dbe}, {31'h0, ~m_boost[0]});
    endtask

    task automatic rst();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        m_peak = 0;
        m_div = 1;
        m_boost = 2;
        @(posedge pclk);
        outs();
        for (int k = 0; k < 3; k++) rdchk(adr[k]);
        idle();
    endtask

    task automatic wro(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        wr(a, d, s);
        idle();
        outs();
    endtask

    // ==========================================================
    // main sequence: codes, locks, strobes, unmapped, random, reset
    initial begin
        void'($urandom(78672));
        lock(0, 0);
        rst();
        for (i = 0; i < 8; i++) wro(adr[0], ($urandom & 32'hFFFFFF88) | (i << 4) | (7 - i), 4'hF);
        for (i = 0; i < 4; i++) wro(adr[1], ($urandom & 32'hFFFFFFFC) | i, 4'h1);
        for (i = 0; i < 8; i++) wro(adr[2], ($urandom & 32'hFFFFFFF8) | i, 4'hF);
        lock(1, 0);
        wro(adr[1], 32'h2, 4'hF);
        wro(adr[2], 32'h5, 4'hF);
        lock(0, 1);
        wro(adr[2], 32'h2, 4'hF);
        wro(adr[1], 32'h3, 4'hF);
        lock(0, 0);
        wro(adr[0], 32'h55, 4'hE);
        wro(8'h30, 32'h33, 4'hF);
        rdchk(8'h30);
        for (i = 0; i < 60; i++) begin
            lock($urandom % 2, $urandom % 2);
            if ($urandom % 2) wr(adr[$urandom % 4], $urandom, 4'($urandom) | 4'(lk_d | lk_b));
            else rdchk(adr[$urandom % 4]);
        end
        idle();
        outs();
        rst();
        end_of_test();
    end
endmodule
